// ==== core/intc_params.svh ====
// Constants for the two-level interrupt controller: register map, bit layout, reset values.
// Assumes a 32-bit AXI4-Lite register port with 8 decoded address bits.
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ADDR_W          8
`define REG_NORM_SIG    8'h00
`define REG_NORM_EN     8'h04
`define REG_NORM_CLR    8'h08
`define REG_NORM_STA    8'h0c
`define REG_FAST_SIG    8'h10
`define REG_FAST_EN     8'h14
`define REG_FAST_CLR    8'h18
`define REG_FAST_STA    8'h1c
`define REG_PROG_CFG    8'h20

// ****************************************
// Bit layout
// ****************************************
`define AGG_BIT         0
`define PROG_BIT        1
`define SRC_LO          2
`define SRC_HI          24
`define EXT_A_BIT       15
`define EXT_B_BIT       18
`define CFG_NORM_BIT    1
`define CFG_FAST_BIT    2
`define EN_IMPL_MASK    32'h01fffffc
`define EN_RESET        32'h00000000
`define CFG_RESET       2'h0

// ****************************************
// Bus answers
// ****************************************
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== core/intc_pkg.sv ====
// Types for the two-level interrupt controller: bus carriers and the state record.
// Assumes intc_params.svh is on the include path.
`include "intc_params.svh"

package intc_pkg;

	typedef struct packed {
		logic [`ADDR_W-1:0] awaddr;
		logic               awvalid;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		logic               wvalid;
		logic               bready;
		logic [`ADDR_W-1:0] araddr;
		logic               arvalid;
		logic               rready;
	} axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;

	typedef struct packed {
		logic [31:0]        nen;
		logic [31:0]        fen;
		logic [2:1]         cfg;
		logic               aw_full;
		logic [`ADDR_W-1:0] aw_addr;
		logic               w_full;
		logic [31:0]        w_data;
		logic [3:0]         w_strb;
		axi_rsp_t           rsp;
		logic               normal_irq;
		logic               fast_irq;
	} state_t;

endpackage : intc_pkg

// ==== core/dual_level_interrupt_controller.sv ====
// Two-level interrupt controller: raw, enable, enable-clear and status views per line.
// Assumes request inputs synchronous to clk and an AXI4-Lite master on the register port.

`include "intc_params.svh"

module dual_level_interrupt_controller (
	// Clock, reset, enable
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	// Request sources
	input  wire logic [`SRC_HI:`SRC_LO] periph_req,
	input  wire logic               external_request_pin_a,
	input  wire logic               external_request_pin_b,
	// Register port
	input  wire intc_pkg::axi_req_t bus_req,
	output intc_pkg::axi_rsp_t      bus_rsp,
	// Processor core lines
	output logic                    normal_interrupt_request,
	output logic                    fast_interrupt_request
);

	// ****************************************
	// Source vector
	// ****************************************
	intc_pkg::state_t st;
	intc_pkg::state_t nx;
	logic [31:0]      src;
	logic [31:0]      byte_mask;

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_src
			if (gi == `EXT_A_BIT) begin : g_a
				assign src[gi] = external_request_pin_a;
			end else if (gi == `EXT_B_BIT) begin : g_b
				assign src[gi] = external_request_pin_b;
			end else if (gi >= `SRC_LO && gi <= `SRC_HI) begin : g_p
				assign src[gi] = periph_req[gi];
			end else begin : g_z
				// Aggregate and programmed positions are filled below, not by a source
				assign src[gi] = 1'b0;
			end
		end
		for (gi = 0; gi < 4; gi++) begin : g_strb
			assign byte_mask[gi*8 +: 8] = {8{st.w_strb[gi]}};
		end
	endgenerate

	// ****************************************
	// State and views
	// ****************************************
	logic [31:0] norm_sig;
	logic [31:0] norm_sta;
	logic [31:0] fast_sig;
	logic [31:0] fast_sta;
	logic [31:0] fast_hi;
	logic        fast_agg;
	logic [31:0] wmask;
	logic        wr_go;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_val;

	always_comb begin
		// Status is raw request qualified by the mask, plus unmaskable programmed bit and the fast aggregate at bit 0
		fast_hi = (src & st.fen) | ({31'h0, st.cfg[`CFG_FAST_BIT]} << `PROG_BIT);
		fast_agg = |fast_hi[31:1];
		fast_sta = fast_hi | {31'h0, fast_agg};
		fast_sig = src | ({31'h0, st.cfg[`CFG_FAST_BIT]} << `PROG_BIT) | {31'h0, fast_agg};
		norm_sta = (src & st.nen) | ({31'h0, st.cfg[`CFG_NORM_BIT]} << `PROG_BIT)
			| {31'h0, fast_agg};
		norm_sig = src | ({31'h0, st.cfg[`CFG_NORM_BIT]} << `PROG_BIT) | {31'h0, fast_agg};
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nx = st;
		wmask = st.w_data & byte_mask & `EN_IMPL_MASK;
		wr_go = st.aw_full && st.w_full && !st.rsp.bvalid;
		wr_hit = 1'b1;
		rd_hit = 1'b1;
		rd_val = 32'h0;

		// Address and data are taken independently, in either order
		if (bus_req.awvalid && st.rsp.awready) begin
			nx.aw_full = 1'b1;
			nx.aw_addr = bus_req.awaddr;
		end
		if (bus_req.wvalid && st.rsp.wready) begin
			nx.w_full = 1'b1;
			nx.w_data = bus_req.wdata;
			nx.w_strb = bus_req.wstrb;
		end
		if (st.rsp.bvalid && bus_req.bready) begin
			nx.rsp.bvalid = 1'b0;
		end

		// Enable writes set bits on their own line and clear them on the other; zero bits change nothing, so no read-modify-write
		if (wr_go) begin
			if (st.aw_addr == `REG_NORM_EN) begin
				nx.nen = st.nen | wmask;
				nx.fen = st.fen & ~wmask;
			end else if (st.aw_addr == `REG_FAST_EN) begin
				nx.fen = st.fen | wmask;
				nx.nen = st.nen & ~wmask;
			end else if (st.aw_addr == `REG_NORM_CLR) begin
				nx.nen = st.nen & ~wmask;
			end else if (st.aw_addr == `REG_FAST_CLR) begin
				nx.fen = st.fen & ~wmask;
			end else if (st.aw_addr == `REG_PROG_CFG) begin
				if (st.w_strb[0]) begin
					nx.cfg = st.w_data[`CFG_FAST_BIT:`CFG_NORM_BIT];
				end
			end else if (st.aw_addr == `REG_NORM_SIG || st.aw_addr == `REG_NORM_STA
				|| st.aw_addr == `REG_FAST_SIG || st.aw_addr == `REG_FAST_STA) begin
				// Read-only views ignore writes but answer OKAY
				wr_hit = 1'b1;
			end else begin
				wr_hit = 1'b0;
			end
			nx.aw_full = 1'b0;
			nx.w_full = 1'b0;
			nx.rsp.bvalid = 1'b1;
			nx.rsp.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end

		// Register decode for reads; the clear registers read as zero
		if (bus_req.araddr == `REG_NORM_SIG) begin
			rd_val = norm_sig;
		end else if (bus_req.araddr == `REG_NORM_EN) begin
			rd_val = st.nen;
		end else if (bus_req.araddr == `REG_NORM_CLR) begin
			rd_val = 32'h0;
		end else if (bus_req.araddr == `REG_NORM_STA) begin
			rd_val = norm_sta;
		end else if (bus_req.araddr == `REG_FAST_SIG) begin
			rd_val = fast_sig;
		end else if (bus_req.araddr == `REG_FAST_EN) begin
			rd_val = st.fen;
		end else if (bus_req.araddr == `REG_FAST_CLR) begin
			rd_val = 32'h0;
		end else if (bus_req.araddr == `REG_FAST_STA) begin
			rd_val = fast_sta;
		end else if (bus_req.araddr == `REG_PROG_CFG) begin
			rd_val = {29'h0, st.cfg, 1'b0};
		end else begin
			rd_hit = 1'b0;
		end

		if (st.rsp.rvalid && bus_req.rready) begin
			nx.rsp.rvalid = 1'b0;
		end
		if (bus_req.arvalid && st.rsp.arready) begin
			nx.rsp.rvalid = 1'b1;
			nx.rsp.rdata = rd_val;
			nx.rsp.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end

		// One transaction of each kind in flight; ready drops while a slot is occupied
		nx.rsp.awready = !nx.aw_full;
		nx.rsp.wready = !nx.w_full;
		nx.rsp.arready = !nx.rsp.rvalid;

		// Only two request kinds reach the core, both registered for a glitch-free line
		nx.normal_irq = |norm_sta;
		nx.fast_irq = fast_agg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else if (ce) begin
			st <= nx;
		end
	end

	assign bus_rsp = st.rsp;
	assign normal_interrupt_request = st.normal_irq;
	assign fast_interrupt_request = st.fast_irq;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_cfg_norm;
		ce && wr_go && st.aw_addr == `REG_PROG_CFG && st.w_strb[0] && st.w_data[`CFG_NORM_BIT];
	endsequence

	sequence s_cfg_fast;
		ce && wr_go && st.aw_addr == `REG_PROG_CFG && st.w_strb[0] && st.w_data[`CFG_FAST_BIT];
	endsequence

	sequence s_cfg_norm_off;
		ce && wr_go && st.aw_addr == `REG_PROG_CFG && st.w_strb[0] && !st.w_data[`CFG_NORM_BIT];
	endsequence

	sequence s_cfg_fast_off;
		ce && wr_go && st.aw_addr == `REG_PROG_CFG && st.w_strb[0] && !st.w_data[`CFG_FAST_BIT];
	endsequence

	sequence s_ro_write;
		ce && wr_go && (st.aw_addr == `REG_NORM_SIG || st.aw_addr == `REG_NORM_STA
			|| st.aw_addr == `REG_FAST_SIG || st.aw_addr == `REG_FAST_STA);
	endsequence

	property p_excl;
		(st.nen & st.fen) == 32'h0;
	endproperty
	a_excl: assert property (p_excl) else $error("source enabled on both lines");

	property p_unimpl;
		((st.nen | st.fen) & ~`EN_IMPL_MASK) == 32'h0;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented enable bit set");

	property p_norm_set;
		ce && wr_go && st.aw_addr == `REG_NORM_EN
			|=> ((st.nen & $past(wmask)) == $past(wmask)) && ((st.fen & $past(wmask)) == 32'h0);
	endproperty
	a_norm_set: assert property (p_norm_set) else $error("normal enable set failed");

	property p_fast_set;
		ce && wr_go && st.aw_addr == `REG_FAST_EN
			|=> ((st.fen & $past(wmask)) == $past(wmask)) && ((st.nen & $past(wmask)) == 32'h0);
	endproperty
	a_fast_set: assert property (p_fast_set) else $error("fast enable set failed");

	property p_clear;
		ce && wr_go && st.aw_addr == `REG_NORM_CLR
			|=> ((st.nen & $past(wmask)) == 32'h0) && ((st.nen | $past(wmask)) == ($past(st.nen) | $past(wmask)));
	endproperty
	a_clear: assert property (p_clear) else $error("enable clear wrong");

	property p_norm_line;
		ce && |norm_sta |=> normal_interrupt_request;
	endproperty
	a_norm_line: assert property (p_norm_line) else $error("normal line missed");

	property p_norm_quiet;
		ce && norm_sta == 32'h0 |=> !normal_interrupt_request;
	endproperty
	a_norm_quiet: assert property (p_norm_quiet) else $error("normal line without status");

	property p_fast_line;
		ce && |fast_sta[31:1] |=> fast_interrupt_request && normal_interrupt_request;
	endproperty
	a_fast_line: assert property (p_fast_line) else $error("fast aggregate not on both lines");

	property p_swi_norm;
		s_cfg_norm ##1 ce |=> normal_interrupt_request;
	endproperty
	a_swi_norm: assert property (p_swi_norm) else $error("programmed normal request lost");

	property p_swi_fast;
		s_cfg_fast ##1 ce |=> fast_interrupt_request;
	endproperty
	a_swi_fast: assert property (p_swi_fast) else $error("programmed fast request lost");

	property p_bhold;
		st.rsp.bvalid && !bus_req.bready |=> st.rsp.bvalid && $stable(st.rsp.bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped early");

	// ****************************************
	// Bus and map checks
	// ****************************************

	property p_rhold;
		st.rsp.rvalid && !bus_req.rready |=> st.rsp.rvalid && $stable(st.rsp.rdata) && $stable(st.rsp.rresp);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped early");

	// Each slot refuses a second item while full, so nothing is overwritten unseen
	property p_slots;
		!(st.aw_full && st.rsp.awready) && !(st.w_full && st.rsp.wready) && !(st.rsp.rvalid && st.rsp.arready);
	endproperty
	a_slots: assert property (p_slots) else $error("ready raised while slot occupied");

	property p_rd_answer;
		ce && bus_req.arvalid && st.rsp.arready |=> st.rsp.rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read taken without answer");

	property p_rd_unmapped;
		ce && bus_req.arvalid && st.rsp.arready && !rd_hit |=> st.rsp.rresp == `RESP_SLVERR;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read answered okay");

	property p_wr_unmapped;
		ce && wr_go && !wr_hit
			|=> st.rsp.bvalid && st.rsp.bresp == `RESP_SLVERR && $stable(st.nen) && $stable(st.fen) && $stable(st.cfg);
	endproperty
	a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write had an effect");

	property p_ro_write;
		s_ro_write |=> st.rsp.bresp == `RESP_OKAY && $stable(st.nen) && $stable(st.fen) && $stable(st.cfg);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("write to read-only view had an effect");

	property p_fast_clear;
		ce && wr_go && st.aw_addr == `REG_FAST_CLR
			|=> ((st.fen & $past(wmask)) == 32'h0) && ((st.fen | $past(wmask)) == ($past(st.fen) | $past(wmask)));
	endproperty
	a_fast_clear: assert property (p_fast_clear) else $error("fast enable clear wrong");

	property p_nclr_keep;
		ce && wr_go && st.aw_addr == `REG_NORM_CLR |=> $stable(st.fen) && $stable(st.cfg);
	endproperty
	a_nclr_keep: assert property (p_nclr_keep) else $error("normal clear touched other state");

	property p_fclr_keep;
		ce && wr_go && st.aw_addr == `REG_FAST_CLR |=> $stable(st.nen) && $stable(st.cfg);
	endproperty
	a_fclr_keep: assert property (p_fclr_keep) else $error("fast clear touched other state");

	property p_norm_mask;
		(norm_sta[31:`SRC_LO] & ~st.nen[31:`SRC_LO]) == 30'h0;
	endproperty
	a_norm_mask: assert property (p_norm_mask) else $error("normal status bit without enable");

	property p_fast_mask;
		(fast_sta[31:`SRC_LO] & ~st.fen[31:`SRC_LO]) == 30'h0;
	endproperty
	a_fast_mask: assert property (p_fast_mask) else $error("fast status bit without enable");

	property p_fast_quiet;
		ce && fast_sta[31:1] == 31'h0 |=> !fast_interrupt_request;
	endproperty
	a_fast_quiet: assert property (p_fast_quiet) else $error("fast line without status");

	property p_pins;
		norm_sig[`EXT_A_BIT] == external_request_pin_a && fast_sig[`EXT_B_BIT] == external_request_pin_b;
	endproperty
	a_pins: assert property (p_pins) else $error("external pin not at its source bit");

	property p_cfg_norm_off;
		s_cfg_norm_off |=> !st.cfg[`CFG_NORM_BIT];
	endproperty
	a_cfg_norm_off: assert property (p_cfg_norm_off) else $error("programmed normal request not cleared");

	property p_cfg_fast_off;
		s_cfg_fast_off |=> !st.cfg[`CFG_FAST_BIT];
	endproperty
	a_cfg_fast_off: assert property (p_cfg_fast_off) else $error("programmed fast request not cleared");

endmodule : dual_level_interrupt_controller

// ==== tb/periph_model.sv ====
// Peripheral side model: drives the request levels seen by the interrupt controller.
// Assumes the bench sets the wanted levels and holds them long enough to be read back.
module periph_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Wanted request levels
	input  wire logic [24:2] want,
	// Lines into the controller
	output logic      [24:2] periph_req,
	output logic             pin_a,
	output logic             pin_b
);
	timeunit 1ns;
	timeprecision 1ps;

	// Levels are held until the bench changes them, far beyond the latency
	// Bits 15 and 18 come from pins, so the shared vector toggles there to expose any use of it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_req <= 23'h0;
			pin_a      <= 1'h0;
			pin_b      <= 1'h0;
		end else begin
			periph_req <= {want[24:19], ~periph_req[18], want[17:16], ~periph_req[15], want[14:2]};
			pin_a      <= want[15];
			pin_b      <= want[18];
		end
	end
endmodule : periph_model

// ==== tb/tb.sv ====
// Self-checking bench for the two-level interrupt controller.
// Assumes the register map and bit layout of intc_params.svh and an AXI4-Lite slave port.
`include "intc_params.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clk;
	logic               rst_n;
	logic               ce;
	logic [24:2]        want;
	logic [24:2]        periph_req;
	logic               pin_a;
	logic               pin_b;
	logic               nirq;
	logic               firq;
	intc_pkg::axi_req_t req;
	intc_pkg::axi_rsp_t rsp;
	int                 errors;
	int                 num_checks;
	logic [31:0]        rd;
	logic [1:0]         resp;

	// ****************************************
	// Instances
	// ****************************************
	periph_model peri (.clk(clk), .rst_n(rst_n), .want(want), .periph_req(periph_req), .pin_a(pin_a),
		.pin_b(pin_b));
	dual_level_interrupt_controller dut (.clk(clk), .rst_n(rst_n), .ce(ce), .periph_req(periph_req),
		.external_request_pin_a(pin_a), .external_request_pin_b(pin_b), .bus_req(req), .bus_rsp(rsp),
		.normal_interrupt_request(nirq), .fast_interrupt_request(firq));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic timed_out;
		errors++;
		$display("ERROR %0t: bus answer never came", $time);
		tally_and_finish();
	endtask : timed_out

	// Each valid stands until its own ready is seen at a rising edge; the answer is taken at the first later edge that shows its valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'h0;
		@(posedge clk);
		req.awaddr  <= a;
		req.wdata   <= d;
		req.wstrb   <= 4'hf;
		req.awvalid <= 1'h1;
		req.wvalid  <= 1'h1;
		req.bready  <= 1'h1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
			if (rsp.bvalid) begin
				done = 1'h1;
				resp = rsp.bresp;
			end
		end
		req.bready <= 1'h0;
		if (!done) timed_out();
	endtask : wr

	task automatic rdreg(input logic [7:0] a);
		logic done;
		done = 1'h0;
		@(posedge clk);
		req.araddr  <= a;
		req.arvalid <= 1'h1;
		req.rready  <= 1'h1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
			if (rsp.rvalid) begin
				done = 1'h1;
				rd   = rsp.rdata;
				resp = rsp.rresp;
			end
		end
		req.rready <= 1'h0;
		if (!done) timed_out();
	endtask : rdreg

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rdreg(a);
		chk(rd, exp);
	endtask : rchk

	// Lines lag the status by one edge and the requests by one more, so settle first
	task automatic lines(input logic [1:0] exp);
		repeat (4) @(posedge clk);
		chk({30'h0, firq, nirq}, {30'h0, exp});
	endtask : lines

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_masks;
		rchk(`REG_NORM_EN, 32'h0);
		rchk(`REG_PROG_CFG, 32'h0);
		lines(2'h0);
		wr(`REG_NORM_EN, 32'hffffffff);
		chk({30'h0, resp}, {30'h0, `RESP_OKAY});
		rchk(`REG_NORM_EN, 32'h01fffffc);
		wr(`REG_NORM_CLR, 32'h0000000c);
		rchk(`REG_NORM_EN, 32'h01fffff0);
		wr(`REG_FAST_EN, 32'h00000010);
		wr(`REG_FAST_EN, 32'h0);
		rchk(`REG_FAST_EN, 32'h00000010);
		rchk(`REG_NORM_EN, 32'h01ffffe0);
		wr(`REG_NORM_EN, 32'h00000010);
		rchk(`REG_FAST_EN, 32'h0);
		wr(`REG_NORM_CLR, 32'hffffffff);
		rchk(`REG_NORM_EN, 32'h0);
	endtask : s_masks

	task automatic s_route;
		want <= 23'h0012001;
		wr(`REG_NORM_EN, 32'h00008004);
		wr(`REG_FAST_EN, 32'h00040000);
		rchk(`REG_NORM_SIG, 32'h00048005);
		rchk(`REG_FAST_SIG, 32'h00048005);
		chk({30'h0, resp}, {30'h0, `RESP_OKAY});
		rchk(`REG_NORM_STA, 32'h00008005);
		rchk(`REG_FAST_STA, 32'h00040001);
		lines(2'h3);
		want <= 23'h0000001;
		lines(2'h1);
		rchk(`REG_FAST_STA, 32'h0);
		wr(`REG_FAST_CLR, 32'h00040000);
		rchk(`REG_FAST_EN, 32'h0);
		wr(`REG_NORM_CLR, 32'h00000004);
		rchk(`REG_NORM_STA, 32'h0);
		lines(2'h0);
		want <= 23'h0;
	endtask : s_route

	task automatic s_prog;
		wr(`REG_PROG_CFG, 32'h00000002);
		rchk(`REG_NORM_STA, 32'h00000002);
		lines(2'h1);
		wr(`REG_PROG_CFG, 32'h00000004);
		rchk(`REG_FAST_STA, 32'h00000003);
		rchk(`REG_NORM_STA, 32'h00000001);
		lines(2'h3);
		wr(`REG_PROG_CFG, 32'h0);
		lines(2'h0);
	endtask : s_prog

	// Clock enable low freezes every flop of the controller, so a new request must not reach the line until it returns
	task automatic s_freeze;
		wr(`REG_NORM_EN, 32'h00008000);
		ce   <= 1'h0;
		want <= 23'h0002000;
		lines(2'h0);
		ce <= 1'h1;
		lines(2'h1);
		want <= 23'h0;
		lines(2'h0);
		wr(`REG_NORM_CLR, 32'h00008000);
		rchk(`REG_NORM_EN, 32'h0);
	endtask : s_freeze

	task automatic s_unmapped;
		wr(`REG_NORM_STA, 32'hffffffff);
		chk({30'h0, resp}, {30'h0, `RESP_OKAY});
		rchk(`REG_NORM_EN, 32'h0);
		wr(8'h40, 32'hffffffff);
		chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
		rdreg(8'h40);
		chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
	endtask : s_unmapped

	// ****************************************
	// Clock, reset and sequence
	// ****************************************
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial begin
		rst_n      = 1'h0;
		ce         = 1'h1;
		want       = 23'h0;
		req        = '0;
		errors     = 0;
		num_checks = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		s_masks();
		s_route();
		s_prog();
		s_freeze();
		s_unmapped();
		tally_and_finish();
	end
endmodule : tb
